// file: verilog/cao_exec.sv
// execute unit for condition tests, alu ops, table call, bit clear and returns
// Functional notes
// - codes 0000/1000 test wrap, 0001 carry
// - code 1001 true when carry is clear
// - codes x010 null, x011 carry or null
// - codes x100 negative, x110 negative xor wrap
// - x111 signed-le, 0101 always, 1101 clamp
// - alu, move and swap ops take one cycle
// - sums/compare set four flags; logic clears wrap
// - taken branch adds offset, two cycles
// - untaken branch steps on, one cycle, no flags
// - move picks source by condition, flags kept
// - halfword swap exchanges bytes per halfword
// - word swap reverses all four bytes
// - table call saves, reads entry, jumps
// - table call takes four cycles with a prompt memory answer or up to two memory waits, longer with more waits
// - returns take three cycles, bit clear three with prompt memory answers
// - returns restore counter and status word
// - condition field is four bits, sixteen tests
//
// Chosen here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module cao_exec (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output cao_pkg::cao_mreq_s mreq,
	input wire cao_pkg::cao_mrsp_s mrsp,
	output logic busy
);
	logic [31:0] gpr [32];
	logic [31:0] pc_q, pstat_q, tcall_ra_q, tcall_st_q, tbase_q, dbg_ra_q, dbg_st_q, ins_q;
	logic [31:0] hrdata_q, rd_mux;
	logic dp_wr_q, taken_q, bclr_q, tcall_q;
	logic [7:0] dp_addr_q;
	logic [2:0] cnt_q, ncyc, bitn, bitn_q;
	cao_pkg::cao_mst_e mst_q;
	cao_pkg::cao_mreq_s mreq_q;
	logic [15:0] lo, hi;
	logic [5:0] op;
	logic [4:0] r1, r2, r3;
	logic [31:0] a, b, x, y, y2, simm, wimm, boff, res, pc_nx, maddr, wr_data;
	logic [32:0] sum;
	logic sub, ar, lg, taken, wr_en, issue, mem_ack, cy, ov;
	logic is_bc, is_cmp, is_hswap, is_tcall, is_tret, is_dret, is_bclr;
	logic [4:0] wr_idx;
	logic [3:0] cc_m;

	// condition evaluator over the status word
	function automatic logic cond_ok(input logic [3:0] cc, input logic [31:0] p);
		logic r;
		case (cc[2:0])
			cao_pkg::CB_WRAP: r = p[cao_pkg::ST_WRAP];
			cao_pkg::CB_CARRY: r = p[cao_pkg::ST_CARRY];
			cao_pkg::CB_NULL: r = p[cao_pkg::ST_NULL];
			cao_pkg::CB_NHI: r = p[cao_pkg::ST_CARRY] | p[cao_pkg::ST_NULL];
			cao_pkg::CB_NEG: r = p[cao_pkg::ST_NEG];
			cao_pkg::CB_TRUE: r = 1'b1;
			cao_pkg::CB_LT: r = p[cao_pkg::ST_NEG] ^ p[cao_pkg::ST_WRAP];
			cao_pkg::CB_LE: r = (p[cao_pkg::ST_NEG] ^ p[cao_pkg::ST_WRAP]) | p[cao_pkg::ST_NULL];
			default: r = 1'b0;
		endcase
		if (cc == cao_pkg::CC_CLAMP) begin
			r = p[cao_pkg::ST_CLAMP] ^ 1'b1;
		end
		return r ^ cc[3];
	endfunction

	// bus slave handshake, zero wait states, frozen with the clock enable
	assign hreadyout = ce;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;
	assign mreq = mreq_q;
	assign busy = (cnt_q != 3'h0) || (mst_q != cao_pkg::M_IDLE);
	assign issue = dp_wr_q && (dp_addr_q == cao_pkg::OFS_INSTR) && !busy;
	assign mem_ack = mreq_q.req && mrsp.ack;

	// read multiplexer, sampled in the address phase
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (haddr[7]) begin
			rd_mux = gpr[haddr[6:2]];
		end else begin
			case (haddr[7:0])
				cao_pkg::OFS_INSTR: rd_mux = ins_q;
				cao_pkg::OFS_STATUS: rd_mux = {30'h0, taken_q, busy};
				cao_pkg::OFS_PC: rd_mux = pc_q;
				cao_pkg::OFS_PSTAT: rd_mux = pstat_q;
				cao_pkg::OFS_TCALL_RA: rd_mux = tcall_ra_q;
				cao_pkg::OFS_TCALL_ST: rd_mux = tcall_st_q;
				cao_pkg::OFS_TBASE: rd_mux = tbase_q;
				cao_pkg::OFS_DBG_RA: rd_mux = dbg_ra_q;
				cao_pkg::OFS_DBG_ST: rd_mux = dbg_st_q;
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end

	// address phase capture and read data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_q <= 1'b0;
			dp_addr_q <= 8'h00;
			hrdata_q <= 32'h0000_0000;
		end else if (ce) begin
			dp_wr_q <= hsel && hready && htrans[1] && hwrite;
			dp_addr_q <= haddr[7:0];
			if (hsel && hready && htrans[1] && !hwrite) begin
				hrdata_q <= rd_mux;
			end
		end
	end

	// instruction fields, taken straight from the written word
	assign lo = hwdata[15:0];
	assign hi = hwdata[31:16];
	assign op = lo[10:5];
	assign r1 = lo[4:0];
	assign r2 = lo[15:11];
	assign r3 = hi[15:11];
	assign a = gpr[r2];
	assign b = gpr[r1];
	assign simm = {{27{lo[4]}}, lo[4:0]};
	assign wimm = {{16{hi[15]}}, hi};
	assign boff = {{23{lo[15]}}, lo[15:11], lo[6:4], 1'b0};
	assign y2 = sub ? ~y : y;
	assign sum = {1'b0, x} + {1'b0, y2} + {32'h0, sub};
	assign res = sum[31:0];
	assign cy = sum[32] ^ sub;
	assign ov = (x[31] == y2[31]) && (res[31] != x[31]);

	// decode and execute at the data phase of an instruction write
	always_comb begin
		x = a;
		y = b;
		sub = 1'b0;
		ar = 1'b0;
		lg = 1'b0;
		wr_en = 1'b0;
		wr_idx = r2;
		wr_data = res;
		ncyc = cao_pkg::CYC_ONE;
		pc_nx = pc_q + cao_pkg::PC_STEP16;
		taken = 1'b0;
		maddr = b;
		bitn = lo[13:11];
		cc_m = hi[4:1];
		is_bc = 1'b0;
		is_cmp = 1'b0;
		is_hswap = 1'b0;
		is_tcall = 1'b0;
		is_tret = 1'b0;
		is_dret = 1'b0;
		is_bclr = 1'b0;
		if (lo[10:7] == cao_pkg::BR_TAG) begin
			is_bc = 1'b1;
			taken = cond_ok(lo[3:0], pstat_q);
			if (taken) begin
				pc_nx = pc_q + boff;
				ncyc = cao_pkg::CYC_BR_TAKEN;
			end
		end else if (lo[15:6] == cao_pkg::TCALL_TAG) begin
			is_tcall = 1'b1;
			maddr = tbase_q + {25'h0, lo[5:0], 1'b0};
			ncyc = cao_pkg::CYC_TCALL;
		end else begin
			case (op)
				cao_pkg::OP_SUM: begin
					wr_en = 1'b1;
					ar = 1'b1;
				end
				cao_pkg::OP_SUM5: begin
					y = simm;
					wr_en = 1'b1;
					ar = 1'b1;
				end
				cao_pkg::OP_SUMI: begin
					x = b;
					y = wimm;
					wr_en = 1'b1;
					ar = 1'b1;
					pc_nx = pc_q + cao_pkg::PC_STEP32;
				end
				cao_pkg::OP_COMPARE, cao_pkg::OP_COMPARE5: begin
					y = op[4] ? simm : b;
					sub = 1'b1;
					ar = 1'b1;
					is_cmp = 1'b1;
				end
				cao_pkg::OP_CONJ: begin
					wr_data = a & b;
					wr_en = 1'b1;
					lg = 1'b1;
				end
				cao_pkg::OP_CONJI: begin
					wr_data = b & {16'h0000, hi};
					wr_en = 1'b1;
					lg = 1'b1;
					pc_nx = pc_q + cao_pkg::PC_STEP32;
				end
				cao_pkg::OP_BCLR_D: begin
					is_bclr = 1'b1;
					maddr = b + wimm;
					ncyc = cao_pkg::CYC_LONG;
					pc_nx = pc_q + cao_pkg::PC_STEP32;
				end
				cao_pkg::OP_EXT: begin
					pc_nx = pc_q + cao_pkg::PC_STEP32;
					wr_idx = r3;
					if ((hi[10:5] == cao_pkg::SUB_CMOVE_I || hi[10:5] == cao_pkg::SUB_CMOVE_R) && !hi[0]) begin
						wr_en = 1'b1;
						taken = cond_ok(cc_m, pstat_q);
						wr_data = taken ? (hi[5] ? b : simm) : a;
					end else if (hi[10:0] == cao_pkg::SUB_HSWAP) begin
						is_hswap = 1'b1;
						wr_en = 1'b1;
						lg = 1'b1;
						wr_data = {a[23:16], a[31:24], a[7:0], a[15:8]};
					end else if (hi[10:0] == cao_pkg::SUB_WSWAP) begin
						wr_en = 1'b1;
						lg = 1'b1;
						wr_data = {a[7:0], a[15:8], a[23:16], a[31:24]};
					end else if (lo == cao_pkg::SYS_LO && hi == cao_pkg::SUB_TRET) begin
						is_tret = 1'b1;
						ncyc = cao_pkg::CYC_LONG;
					end else if (lo == cao_pkg::SYS_LO && hi == cao_pkg::SUB_DRET) begin
						is_dret = 1'b1;
						ncyc = cao_pkg::CYC_LONG;
					end else if (hi == cao_pkg::SUB_BCLR_R) begin
						is_bclr = 1'b1;
						bitn = a[2:0];
						ncyc = cao_pkg::CYC_LONG;
					end
				end
				default: ;
			endcase
		end
	end

	// general registers, entry zero reads as zero
	assign gpr[0] = 32'h0000_0000;
	for (genvar i = 1; i < 32; i++) begin : g_gpr
		logic [31:0] q;
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				q <= 32'h0000_0000;
			end else if (ce) begin
				if (issue && wr_en && wr_idx == 5'(i)) begin
					q <= wr_data;
				end else if (dp_wr_q && dp_addr_q == (cao_pkg::OFS_GPR | 8'(i * 4))) begin
					q <= hwdata;
				end
			end
		end
		assign gpr[i] = q;
	end

	// occupancy counter and last issued word
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 3'h0;
			ins_q <= 32'h0000_0000;
			taken_q <= 1'b0;
		end else if (ce) begin
			if (issue) begin
				cnt_q <= ncyc - 3'h1;
				ins_q <= hwdata;
				taken_q <= taken;
			end else if (cnt_q != 3'h0) begin
				cnt_q <= cnt_q - 3'h1;
			end
		end
	end

	// memory sequencer for table fetch and bit read-modify-write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mst_q <= cao_pkg::M_IDLE;
			mreq_q <= '0;
			bitn_q <= 3'h0;
			bclr_q <= 1'b0;
			tcall_q <= 1'b0;
		end else if (ce) begin
			case (mst_q)
				cao_pkg::M_IDLE: begin
					if (issue && (is_tcall || is_bclr)) begin
						mst_q <= cao_pkg::M_RD;
						mreq_q <= '{req: 1'b1, we: 1'b0, hw: is_tcall, addr: maddr, wdata: 8'h00};
						bitn_q <= bitn;
						bclr_q <= is_bclr;
						tcall_q <= is_tcall;
					end
				end
				cao_pkg::M_RD: begin
					if (mem_ack && bclr_q) begin
						mst_q <= cao_pkg::M_WR;
						mreq_q.we <= 1'b1;
						mreq_q.wdata <= mrsp.rdata[7:0] & ~(8'h01 << bitn_q);
					end else if (mem_ack) begin
						mst_q <= cao_pkg::M_IDLE;
						mreq_q.req <= 1'b0;
					end
				end
				cao_pkg::M_WR: begin
					if (mem_ack) begin
						mst_q <= cao_pkg::M_IDLE;
						mreq_q <= '0;
					end
				end
				default: mst_q <= cao_pkg::M_IDLE;
			endcase
		end
	end

	// program counter and status word
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc_q <= cao_pkg::PC_RST;
			pstat_q <= cao_pkg::PSTAT_RST;
		end else if (ce) begin
			if (issue) begin
				pc_q <= is_tret ? tcall_ra_q : (is_dret ? dbg_ra_q : pc_nx);
				if (is_tret) begin
					pstat_q <= tcall_st_q;
				end else if (is_dret) begin
					pstat_q <= dbg_st_q;
				end else if (ar) begin
					pstat_q[cao_pkg::ST_CARRY] <= cy;
					pstat_q[cao_pkg::ST_WRAP] <= ov;
					pstat_q[cao_pkg::ST_NEG] <= res[31];
					pstat_q[cao_pkg::ST_NULL] <= (res == 32'h0000_0000);
				end else if (lg) begin
					pstat_q[cao_pkg::ST_WRAP] <= 1'b0;
					pstat_q[cao_pkg::ST_NEG] <= wr_data[31];
					pstat_q[cao_pkg::ST_NULL] <= (wr_data == 32'h0000_0000);
				end
			end else if (mst_q == cao_pkg::M_RD && mem_ack) begin
				if (tcall_q) begin
					pc_q <= tbase_q + {16'h0000, mrsp.rdata};
				end else begin
					pstat_q[cao_pkg::ST_NULL] <= ~mrsp.rdata[bitn_q];
				end
			end else if (dp_wr_q && dp_addr_q == cao_pkg::OFS_PC) begin
				pc_q <= hwdata;
			end else if (dp_wr_q && dp_addr_q == cao_pkg::OFS_PSTAT) begin
				pstat_q <= hwdata;
			end
		end
	end

	// saved return state and table base
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tcall_ra_q <= 32'h0000_0000;
			tcall_st_q <= 32'h0000_0000;
			tbase_q <= 32'h0000_0000;
			dbg_ra_q <= 32'h0000_0000;
			dbg_st_q <= 32'h0000_0000;
		end else if (ce) begin
			if (issue && is_tcall) begin
				tcall_ra_q <= pc_q + cao_pkg::PC_STEP16;
				tcall_st_q <= pstat_q;
			end else if (dp_wr_q) begin
				case (dp_addr_q)
					cao_pkg::OFS_TCALL_RA: tcall_ra_q <= hwdata;
					cao_pkg::OFS_TCALL_ST: tcall_st_q <= hwdata;
					cao_pkg::OFS_TBASE: tbase_q <= hwdata;
					cao_pkg::OFS_DBG_RA: dbg_ra_q <= hwdata;
					cao_pkg::OFS_DBG_ST: dbg_st_q <= hwdata;
					default: ;
				endcase
			end
		end
	end

	// checks on the execute path
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn || !ce);

	AST_CC_WRAP: assert property (issue && is_bc && lo[3:0] == 4'h0 |-> taken == pstat_q[cao_pkg::ST_WRAP])
		else $error("wrap test wrong");
	AST_CC_NLOW: assert property (issue && is_bc && lo[3:0] == 4'h9 |-> taken == !pstat_q[cao_pkg::ST_CARRY])
		else $error("not-lower test wrong");
	AST_CC_NHI: assert property (issue && is_bc && lo[3:0] == 4'h3
		|-> taken == (pstat_q[cao_pkg::ST_CARRY] | pstat_q[cao_pkg::ST_NULL]))
		else $error("not-higher test wrong");
	AST_CC_LT: assert property (issue && is_bc && lo[3:0] == 4'h6
		|-> taken == (pstat_q[cao_pkg::ST_NEG] ^ pstat_q[cao_pkg::ST_WRAP]))
		else $error("signed less test wrong");
	AST_CC_CLAMP: assert property (issue && is_bc && lo[3:0] == 4'hd |-> taken == pstat_q[cao_pkg::ST_CLAMP])
		else $error("clamp test wrong");
	AST_ALU_ONE: assert property (issue && (ar || lg) |=> !busy)
		else $error("alu op not single cycle");
	AST_CMP_NULL: assert property (issue && is_cmp |=> pstat_q[cao_pkg::ST_NULL] == ($past(x) == $past(y)))
		else $error("compare null flag wrong");
	AST_BR_TAKEN: assert property (issue && is_bc && taken
		|=> busy && pc_q == $past(pc_q) + $past(boff) ##1 !busy)
		else $error("taken branch wrong");
	AST_BR_NOT: assert property (issue && is_bc && !taken
		|=> !busy && pc_q == $past(pc_q) + cao_pkg::PC_STEP16 && $stable(pstat_q))
		else $error("untaken branch wrong");
	AST_HSWAP: assert property (issue && is_hswap && r3 != 5'h00
		|=> gpr[$past(r3)] == {$past(a[23:16]), $past(a[31:24]), $past(a[7:0]), $past(a[15:8])})
		else $error("halfword swap wrong");
	AST_TCALL: assert property (issue && is_tcall |=> busy [*3])
		else $error("table call too short");
	AST_RET_LEN: assert property (issue && (is_tret || is_dret) |=> busy ##1 busy ##1 !busy)
		else $error("return length wrong");
	AST_TRET: assert property (issue && is_tret |=> pc_q == $past(tcall_ra_q) && pstat_q == $past(tcall_st_q))
		else $error("table return restore wrong");

	COV_BR_TAKEN: cover property (issue && is_bc && taken ##2 !busy);
	COV_TCALL_DONE: cover property (issue && is_tcall ##[1:20] mst_q == cao_pkg::M_IDLE && !busy);
	COV_BCLR_WR: cover property (mst_q == cao_pkg::M_WR && mem_ack);
	COV_DRET: cover property (issue && is_dret);
endmodule // cao_exec
`default_nettype wire

// file: verilog/cao_pkg.sv
// package with register map, field layout, encodings and timing of the execute unit
package cao_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_INSTR = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_PC = 8'h08;
	localparam logic [7:0] OFS_PSTAT = 8'h0c;
	localparam logic [7:0] OFS_TCALL_RA = 8'h10;
	localparam logic [7:0] OFS_TCALL_ST = 8'h14;
	localparam logic [7:0] OFS_TBASE = 8'h18;
	localparam logic [7:0] OFS_DBG_RA = 8'h1c;
	localparam logic [7:0] OFS_DBG_ST = 8'h20;
	localparam logic [7:0] OFS_GPR = 8'h80;
	// status word bit positions
	localparam int ST_NULL = 0;
	localparam int ST_NEG = 1;
	localparam int ST_WRAP = 2;
	localparam int ST_CARRY = 3;
	localparam int ST_CLAMP = 4;
	// reset values
	localparam logic [31:0] PC_RST = 32'h0000_0000;
	localparam logic [31:0] PSTAT_RST = 32'h0000_0000;
	// program counter steps
	localparam logic [31:0] PC_STEP16 = 32'h0000_0002;
	localparam logic [31:0] PC_STEP32 = 32'h0000_0004;
	// cycle counts
	localparam logic [2:0] CYC_ONE = 3'h1;
	localparam logic [2:0] CYC_BR_TAKEN = 3'h2;
	localparam logic [2:0] CYC_LONG = 3'h3;
	localparam logic [2:0] CYC_TCALL = 3'h4;
	// primary opcodes, bits 10:5 of the first halfword; branch tag bits 10:7, table call tag bits 15:6
	localparam logic [5:0] OP_SUM = 6'h0e;
	localparam logic [5:0] OP_SUM5 = 6'h12;
	localparam logic [5:0] OP_SUMI = 6'h30;
	localparam logic [5:0] OP_CONJ = 6'h0a;
	localparam logic [5:0] OP_CONJI = 6'h36;
	localparam logic [5:0] OP_COMPARE = 6'h0f;
	localparam logic [5:0] OP_COMPARE5 = 6'h13;
	localparam logic [5:0] OP_BCLR_D = 6'h3e;
	localparam logic [5:0] OP_EXT = 6'h3f;
	localparam logic [3:0] BR_TAG = 4'hb;
	localparam logic [9:0] TCALL_TAG = 10'h008;
	// second halfword subcodes, and the first halfword of the system returns
	localparam logic [5:0] SUB_CMOVE_I = 6'h18;
	localparam logic [5:0] SUB_CMOVE_R = 6'h19;
	localparam logic [10:0] SUB_HSWAP = 11'h342;
	localparam logic [10:0] SUB_WSWAP = 11'h340;
	localparam logic [15:0] SYS_LO = 16'h07e0;
	localparam logic [15:0] SUB_TRET = 16'h0144;
	localparam logic [15:0] SUB_DRET = 16'h0146;
	localparam logic [15:0] SUB_BCLR_R = 16'h00e4;
	// condition base tests, bit 3 of the code inverts
	localparam logic [2:0] CB_WRAP = 3'h0;
	localparam logic [2:0] CB_CARRY = 3'h1;
	localparam logic [2:0] CB_NULL = 3'h2;
	localparam logic [2:0] CB_NHI = 3'h3;
	localparam logic [2:0] CB_NEG = 3'h4;
	localparam logic [2:0] CB_TRUE = 3'h5;
	localparam logic [2:0] CB_LT = 3'h6;
	localparam logic [2:0] CB_LE = 3'h7;
	localparam logic [3:0] CC_CLAMP = 4'hd;
	// memory request and answer
	typedef struct packed {
		logic req;
		logic we;
		logic hw;
		logic [31:0] addr;
		logic [7:0] wdata;
	} cao_mreq_s;
	typedef struct packed {
		logic ack;
		logic [15:0] rdata;
	} cao_mrsp_s;
	typedef enum {M_IDLE, M_RD, M_WR} cao_mst_e;
endpackage

// file: tb/cao_mem_model.sv
// memory model answering the execute unit's byte and halfword requests
`timescale 1ns/1ps
`default_nettype none
module cao_mem_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire cao_pkg::cao_mreq_s mreq,
	output cao_pkg::cao_mrsp_s mrsp,
	input wire logic [3:0] dly,
	output logic [31:0] last_rd
);
	logic [7:0] mem [0:255];
	logic [3:0] wait_q;
	logic [15:0] noise_q;
	logic [7:0] a;
	// byte i holds i xor a5 so every location differs
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'ha5;
		end
	end
	assign a = mreq.addr[7:0];
	// answer after dly waiting cycles; read data is noise outside the answer
	always_comb begin
		mrsp.ack = mreq.req && (wait_q >= dly);
		mrsp.rdata = noise_q;
		if (mrsp.ack && !mreq.we) begin
			mrsp.rdata = mreq.hw ? {mem[a + 8'h1], mem[a]} : {noise_q[15:8], mem[a]};
		end
	end
	// count waits, store byte writes, remember read addresses
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_q <= 4'h0;
			noise_q <= 16'h1234;
			last_rd <= 32'h0;
		end else begin
			noise_q <= ~{noise_q[14:0], noise_q[15]};
			wait_q <= (mreq.req && !mrsp.ack) ? wait_q + 4'h1 : 4'h0;
			if (mrsp.ack && mreq.we) mem[a] <= mreq.wdata;
			if (mrsp.ack && !mreq.we) last_rd <= mreq.addr;
		end
	end
endmodule // cao_mem_model
`default_nettype wire

// file: tb/tb_top.sv
// self-checking testbench for the condition, alu, table call and return unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [31:0] PC = 32'h8;
	localparam logic [31:0] PST = 32'hc;
	localparam logic [31:0] A1 = 32'h7f12_3456;
	localparam logic [31:0] A2 = 32'h7fff_ffff;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [3:0] dly = 4'h0;
	logic hreadyout, hresp, busy;
	logic [31:0] hrdata, last_rd;
	cao_pkg::cao_mreq_s mreq;
	cao_pkg::cao_mrsp_s mrsp;
	int n_mismatch = 0;
	int num_checks = 0;
	// 50 MHz clock
	always #10 hclk = ~hclk;
	cao_exec cao_exec_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mreq(mreq), .mrsp(mrsp), .busy(busy));
	cao_mem_model cao_mem_model_inst (.hclk(hclk), .hresetn(hresetn), .mreq(mreq), .mrsp(mrsp),
		.dly(dly), .last_rd(last_rd));
	// verdict and end of run
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// compare one value
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// a wait that ran out ends the run
	task automatic tmo();
		n_mismatch++;
		$display("CHECK FAILED wait expected done seen timeout");
		tally_and_finish();
	endtask
	// one single word transfer, each phase held until hready is seen high
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) tmo();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) tmo();
		rd = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		ahb(1'b0, a, 32'h0, d);
	endtask
	function automatic logic [31:0] ga(input int n);
		return 32'h80 + 32'(4 * n);
	endfunction
	// write an instruction, then count the cycles it occupies the unit
	task automatic issue(input logic [31:0] ins, output int cyc);
		wr(32'h0, ins);
		#1;
		cyc = 1;
		while (busy !== 1'b0 && cyc < 40) begin
			@(posedge hclk);
			#1;
			cyc++;
		end
		if (cyc >= 40) tmo();
		@(posedge hclk);
	endtask
	function automatic logic cond_ok(input logic [3:0] c, input logic [4:0] f);
		logic t;
		case (c[2:0])
			3'h0: t = f[2];
			3'h1: t = f[3];
			3'h2: t = f[0];
			3'h3: t = f[3] | f[0];
			3'h4: t = f[1];
			3'h5: t = 1'b1;
			3'h6: t = f[1] ^ f[2];
			default: t = (f[1] ^ f[2]) | f[0];
		endcase
		if (c == 4'hd) return f[4];
		return c[3] ? ~t : t;
	endfunction
	// status word with clamp kept set
	function automatic logic [31:0] fw(input logic cy, input logic v, input logic [31:0] r);
		return {27'h0, 1'b1, cy, v, r[31], r == 32'h0};
	endfunction
	function automatic logic [31:0] sumf(input logic [31:0] a, input logic [31:0] b);
		logic [32:0] s;
		s = {1'b0, a} + {1'b0, b};
		return fw(s[32], a[31] == b[31] && s[31] != a[31], s[31:0]);
	endfunction
	function automatic logic [31:0] subf(input logic [31:0] a, input logic [31:0] b);
		logic [31:0] r;
		r = a - b;
		return fw(a < b, a[31] != b[31] && r[31] != a[31], r);
	endfunction
	function automatic logic [31:0] i2(input logic [4:0] r2, input logic [5:0] op, input logic [4:0] r1,
		input logic [15:0] hi);
		return {hi, r2, op, r1};
	endfunction
	// every code against every flag pattern, forward and backward offsets
	task automatic sc_branch();
		int n;
		logic [31:0] d, e;
		logic [8:0] off;
		logic t;
		for (int f = 0; f < 32; f++) begin
			for (int c = 0; c < 16; c++) begin
				off = c[0] ? 9'h1f0 : 9'h010;
				t = cond_ok(c[3:0], f[4:0]);
				e = t ? 32'h100 + {{23{off[8]}}, off} : 32'h102;
				wr(PST, 32'(f));
				wr(PC, 32'h100);
				issue({16'h0, off[8:4], cao_pkg::BR_TAG, off[3:1], c[3:0]}, n);
				check("branch cycles", 32'(n), t ? 32'h2 : 32'h1);
				rd(PC, d);
				check("branch pc", d, e);
				rd(PST, d);
				check("branch flags", d, 32'(f));
				rd(32'h4, d);
				check("branch status", d, {30'h0, t, 1'b0});
			end
		end
	endtask
	// one-cycle op on preset registers, result and masked flags
	task automatic alu(input logic [31:0] ins, input int dst, input logic [31:0] er, input logic [31:0] ef,
		input logic [31:0] m);
		int n;
		logic [31:0] d;
		wr(ga(1), A1);
		wr(ga(2), A2);
		wr(PST, 32'h1f);
		issue(ins, n);
		check("alu cycles", 32'(n), 32'h1);
		rd(ga(dst), d);
		check("alu result", d, er);
		rd(PST, d);
		check("alu flags", d & m, ef & m);
	endtask
	// memory op, answer delay as set by the caller
	task automatic memop(input logic [31:0] ins, input int cyc, input logic [31:0] pst, input logic [31:0] ep,
		input logic [31:0] est);
		int n;
		logic [31:0] d;
		wr(PST, pst);
		issue(ins, n);
		if (cyc > 0) check("mem cycles", 32'(n), 32'(cyc));
		rd(PC, d);
		if (ep != 32'h0) check("mem pc", d, ep);
		rd(PST, d);
		check("mem status", d, est);
	endtask
	// every one-cycle op on preset registers
	task automatic sc_alu();
		alu(i2(5'd2, cao_pkg::OP_SUM, 5'd1, 16'h0), 2, A2 + A1, sumf(A2, A1), 32'h1f);
		alu(i2(5'd2, cao_pkg::OP_SUM5, 5'h1f, 16'h0), 2, A2 - 32'h1, sumf(A2, 32'hffff_ffff), 32'h1f);
		alu(i2(5'd2, cao_pkg::OP_SUMI, 5'd1, 16'h8000), 2, A1 + 32'hffff_8000, sumf(A1, 32'hffff_8000), 32'h1f);
		alu(i2(5'd2, cao_pkg::OP_CONJ, 5'd1, 16'h0), 2, A2 & A1, fw(1'b1, 1'b0, A2 & A1), 32'h1f);
		alu(i2(5'd2, cao_pkg::OP_CONJI, 5'd1, 16'h8001), 2, A1 & 32'h8001, fw(1'b1, 1'b0, 32'h0), 32'h1f);
		alu(i2(5'd2, cao_pkg::OP_COMPARE, 5'd1, 16'h0), 2, A2, subf(A2, A1), 32'h1f);
		alu(i2(5'd2, cao_pkg::OP_COMPARE5, 5'h10, 16'h0), 2, A2, subf(A2, 32'hffff_fff0), 32'h1f);
		alu(i2(5'd1, 6'h3f, 5'd0, {5'd3, cao_pkg::SUB_HSWAP}), 3, {A1[23:16], A1[31:24], A1[7:0], A1[15:8]},
			fw(1'b0, 1'b0, 32'h1), 32'h17);
		alu(i2(5'd1, 6'h3f, 5'd0, {5'd3, cao_pkg::SUB_WSWAP}), 3, {A1[7:0], A1[15:8], A1[23:16], A1[31:24]},
			fw(1'b0, 1'b0, 32'h1), 32'h17);
		alu(i2(5'd2, 6'h3f, 5'd1, {5'd3, cao_pkg::SUB_CMOVE_R, 4'h3, 1'b0}), 3, A1, 32'h1f, 32'h1f);
		alu(i2(5'd2, 6'h3f, 5'd1, {5'd3, cao_pkg::SUB_CMOVE_R, 4'hb, 1'b0}), 3, A2, 32'h1f, 32'h1f);
		alu(i2(5'd2, 6'h3f, 5'h1e, {5'd3, cao_pkg::SUB_CMOVE_I, 4'hd, 1'b0}), 3, 32'hffff_fffe, 32'h1f, 32'h1f);
		alu(i2(5'd2, 6'h3f, 5'd1, {5'd3, cao_pkg::SUB_CMOVE_R, 4'h5, 1'b0}), 3, A1, 32'h1f, 32'h1f);
	endtask
	// table entry at 0x100a holds bytes 0a^a5, 0b^a5; prompt then slow answers
	task automatic sc_table();
		logic [31:0] d;
		for (int k = 0; k < 2; k++) begin
			dly <= k ? 4'h3 : 4'h0;
			wr(32'h18, 32'h1000);
			wr(PC, 32'h200);
			memop(32'h0000_0205, k ? 0 : 4, 32'h0a, 32'h1000 + 32'hae_af, 32'h0a);
			check("table addr", last_rd, 32'h100a);
			rd(32'h10, d);
			check("table return", d, 32'h202);
			rd(32'h14, d);
			check("table status", d, 32'h0a);
		end
		dly <= 4'h0;
	endtask
	// byte 40 starts as e5: clear bit 2, then bit 3 through a negative offset
	task automatic sc_bclr();
		wr(ga(1), 32'h40);
		wr(ga(2), 32'h2);
		memop(i2(5'd2, 6'h3f, 5'd1, cao_pkg::SUB_BCLR_R), 3, 32'h1, 32'h0, 32'h0);
		check("bit clear byte", {24'h0, cao_mem_model_inst.mem[8'h40]}, 32'he1);
		wr(ga(1), 32'h50);
		memop(i2(5'b10011, cao_pkg::OP_BCLR_D, 5'd1, 16'hfff0), 3, 32'h0, 32'h0, 32'h1);
		check("bit clear kept", {24'h0, cao_mem_model_inst.mem[8'h40]}, 32'he1);
	endtask
	// both returns restore counter and status word
	task automatic sc_ret();
		wr(32'h10, 32'h346);
		wr(32'h14, 32'h1b);
		memop({cao_pkg::SUB_TRET, cao_pkg::SYS_LO}, 3, 32'h4, 32'h346, 32'h1b);
		wr(32'h1c, 32'h2468);
		wr(32'h20, 32'h04);
		memop({cao_pkg::SUB_DRET, cao_pkg::SYS_LO}, 3, 32'h1b, 32'h2468, 32'h04);
	endtask
	// reset, then each scenario in turn
	initial begin
		logic [31:0] d;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(PC, d);
		check("reset pc", d, cao_pkg::PC_RST);
		check("bus response", {31'h0, hresp}, 32'h0);
		sc_branch();
		sc_alu();
		sc_table();
		sc_bclr();
		sc_ret();
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire
